// File: logic/dalu_defines.svh
`ifndef DALU_DEFINES_SVH
`define DALU_DEFINES_SVH

// ****************************************************************
// instruction encodings
// ****************************************************************
`define DALU_OPC_EXTENSION    6'h1f
`define DALU_FN_ADD_GROUP     6'h10
`define DALU_FN_HALVE_GROUP   6'h18
`define DALU_FN_APPEND_GROUP  6'h31
`define DALU_SUB_ADD_CARRY    5'h11
`define DALU_SUB_HALVE_TRUNC  5'h00
`define DALU_SUB_HALVE_ROUND  5'h02
`define DALU_SUB_APPEND       5'h00

// ****************************************************************
// control register fields and reset values
// ****************************************************************
`define DALU_CTL_CARRY_BIT    13
`define DALU_CTL_OUFLAG_BIT   20
`define DALU_CTL_RESET        32'h0000_0000
`define DALU_DATA_RESET       64'h0000_0000_0000_0000
`define DALU_ROUND_ADD        9'h001
`endif

// File: logic/dalu_pkg.sv
package dalu_pkg;

  // ****************************************************************
  // instruction word layout
  // ****************************************************************
  typedef struct packed {
    logic [5:0] major;
    logic [4:0] first_source_index;
    logic [4:0] second_source_index;
    logic [4:0] dest_field;
    logic [4:0] sub_field;
    logic [5:0] func_field;
  } dalu_instr_t;

  // ****************************************************************
  // operation kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    DALU_OP_NONE        = 3'b000,
    DALU_OP_ADD_CARRY   = 3'b001,
    DALU_OP_HALVE_TRUNC = 3'b010,
    DALU_OP_HALVE_ROUND = 3'b011,
    DALU_OP_APPEND      = 3'b100
  } dalu_op_t;

  // ****************************************************************
  // register-file write-back
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [63:0] data;
  } dalu_wb_t;

endpackage : dalu_pkg

// File: logic/dalu_core.sv
`timescale 1ns/1ps
`include "dalu_defines.svh"

module dalu_core (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_issue,
  input  wire dalu_pkg::dalu_instr_t i_instr,
  input  wire logic [63:0]        i_first_source,
  input  wire logic [63:0]        i_second_source,
  input  wire logic [31:0]        i_dsp_control,
  output      dalu_pkg::dalu_wb_t o_wb,
  output      logic               o_ctl_we,
  output      logic [31:0]        o_dsp_control,
  output      logic               o_no_match
);

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic ext_major;
  wire logic is_add_carry;
  wire logic is_halve_trunc;
  wire logic is_halve_round;
  wire logic is_append;
  wire dalu_pkg::dalu_op_t op;

  assign ext_major      = (i_instr.major == `DALU_OPC_EXTENSION);
  assign is_add_carry   = ext_major && (i_instr.func_field == `DALU_FN_ADD_GROUP)
                          && (i_instr.sub_field == `DALU_SUB_ADD_CARRY);
  assign is_halve_trunc = ext_major && (i_instr.func_field == `DALU_FN_HALVE_GROUP)
                          && (i_instr.sub_field == `DALU_SUB_HALVE_TRUNC);
  assign is_halve_round = ext_major && (i_instr.func_field == `DALU_FN_HALVE_GROUP)
                          && (i_instr.sub_field == `DALU_SUB_HALVE_ROUND);
  assign is_append      = ext_major && (i_instr.func_field == `DALU_FN_APPEND_GROUP)
                          && (i_instr.sub_field == `DALU_SUB_APPEND);

  assign op = is_add_carry   ? dalu_pkg::DALU_OP_ADD_CARRY   :
              is_halve_trunc ? dalu_pkg::DALU_OP_HALVE_TRUNC :
              is_halve_round ? dalu_pkg::DALU_OP_HALVE_ROUND :
              is_append      ? dalu_pkg::DALU_OP_APPEND      :
                               dalu_pkg::DALU_OP_NONE;

  // ****************************************************************
  // add word with carry
  // ****************************************************************
  wire logic [31:0] src_a;
  wire logic [31:0] src_b;
  wire logic        carry_in;
  wire logic [32:0] carry_sum;
  wire logic        overflow;

  assign src_a     = i_first_source[31:0];
  assign src_b     = i_second_source[31:0];
  // carry bit is taken from bit 13 of the incoming control word; no op here sets it
  assign carry_in  = i_dsp_control[`DALU_CTL_CARRY_BIT];
  assign carry_sum = {src_a[31], src_a} + {src_b[31], src_b}
                     + {32'h0000_0000, carry_in};
  assign overflow  = carry_sum[32] ^ carry_sum[31];

  // ****************************************************************
  // quad byte halving add
  // ****************************************************************
  wire logic        round_en;
  wire logic [31:0] halve_word;

  assign round_en = is_halve_round;

  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    wire logic [8:0] lane_sum;
    wire logic [8:0] lane_rnd;
    assign lane_sum = {1'b0, src_a[lane*8 +: 8]} + {1'b0, src_b[lane*8 +: 8]};
    assign lane_rnd = lane_sum + (round_en ? `DALU_ROUND_ADD : 9'h000);
    assign halve_word[lane*8 +: 8] = lane_rnd[8:1];
  end

  // ****************************************************************
  // shift and append
  // ****************************************************************
  wire logic [4:0]  shift_count_field;
  wire logic [31:0] append_mask;
  wire logic [31:0] append_word;

  assign shift_count_field = i_instr.dest_field;
  // a zero count gives an empty mask, so the low word of the target comes back untouched
  assign append_mask = ~(32'hffff_ffff << shift_count_field);
  assign append_word = (src_b << shift_count_field)
                       | (src_a & append_mask);

  // ****************************************************************
  // result selection
  // ****************************************************************
  wire logic [31:0] result_word;
  wire logic [63:0] result_ext;
  wire logic [4:0]  result_index;
  wire logic [31:0] next_ctl;
  wire logic        next_ctl_we;
  wire logic        hit;

  assign result_word = (op == dalu_pkg::DALU_OP_ADD_CARRY) ? carry_sum[31:0] :
                       (op == dalu_pkg::DALU_OP_APPEND)    ? append_word     :
                                                             halve_word;
  // bit 31 of the halve word is bit 7 of the top lane
  assign result_ext   = {{32{result_word[31]}}, result_word};
  assign result_index = (op == dalu_pkg::DALU_OP_APPEND) ? i_instr.second_source_index
                                                         : i_instr.dest_field;
  assign hit          = i_issue && (op != dalu_pkg::DALU_OP_NONE);
  // only add-with-carry ever touches the control word; halving adds never do
  assign next_ctl_we  = hit && (op == dalu_pkg::DALU_OP_ADD_CARRY);
  assign next_ctl     = i_dsp_control
                        | ({31'h0000_0000, overflow} << `DALU_CTL_OUFLAG_BIT);

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wb          <= '{valid: 1'b0, index: 5'h00, data: `DALU_DATA_RESET};
      o_ctl_we      <= 1'b0;
      o_dsp_control <= `DALU_CTL_RESET;
      o_no_match    <= 1'b0;
    end else begin
      o_wb.valid    <= hit;
      o_wb.index    <= result_index;
      o_wb.data     <= result_ext;
      o_ctl_we      <= next_ctl_we;
      o_dsp_control <= next_ctl;
      o_no_match    <= i_issue && !hit;
    end
  end

endmodule : dalu_core

// File: sim/dalu_checker.sv
`timescale 1ns/1ps
module dalu_checker (
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_issue,
  input wire dalu_pkg::dalu_instr_t i_instr,
  input wire logic [63:0]           i_first_source,
  input wire logic [63:0]           i_second_source,
  input wire logic [31:0]           i_dsp_control,
  input wire dalu_pkg::dalu_wb_t    o_wb,
  input wire logic                  o_ctl_we,
  input wire logic [31:0]           o_dsp_control,
  input wire logic                  o_no_match
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire ext = i_issue && i_instr.major == 6'h1f;
  wire add = ext && i_instr.func_field == 6'h10 && i_instr.sub_field == 5'h11;
  wire hlv = ext && i_instr.func_field == 6'h18 && i_instr.sub_field inside {5'h00, 5'h02};
  wire app = ext && i_instr.func_field == 6'h31 && i_instr.sub_field == 5'h00;
  wire zsh = app && i_instr.dest_field == 5'h00;
  wire nzsh = app && i_instr.dest_field != 5'h00;
  wire [4:0] app_tgt = i_instr.second_source_index;
  wire [31:0] tgt_lo = i_second_source[31:0];
  // reference carry add built from the rule, not from the design's wires
  wire [32:0] sum33 = {i_first_source[31], i_first_source[31:0]}
                      + {i_second_source[31], i_second_source[31:0]}
                      + {32'h0000_0000, i_dsp_control[13]};
  wire ovf_flag = i_dsp_control[20] || (sum33[32] ^ sum33[31]);
  wire [30:0] ctl_keep = {i_dsp_control[31:21], i_dsp_control[19:0]};
  wire [30:0] ctl_kept = {o_dsp_control[31:21], o_dsp_control[19:0]};
  result_pulse_a: assert property (o_wb.valid |-> $past(i_issue))
    else $error("result without issue");
  carry_write_a: assert property (o_ctl_we |-> $past(add))
    else $error("control write without add");
  halve_clean_a: assert property (hlv |=> o_wb.valid && !o_ctl_we)
    else $error("halving add result or control write wrong");
  append_index_a: assert property (app |=> o_wb.valid && o_wb.index == $past(app_tgt))
    else $error("append target index wrong");
  append_zero_a: assert property (zsh |=> o_wb.data[31:0] == $past(tgt_lo))
    else $error("zero shift changed word");
  append_fill_a: assert property (nzsh |=> o_wb.data[0] == $past(i_first_source[0]))
    else $error("appended bit wrong");
  carry_sum_a: assert property (o_ctl_we |-> o_wb.data[31:0] == $past(sum33[31:0]))
    else $error("carry add sum wrong");
  ovf_set_a: assert property (o_ctl_we |-> o_dsp_control[20] == $past(ovf_flag))
    else $error("overflow flag wrong");
  sign_ext_a: assert property (o_wb.valid |-> o_wb.data[63:32] == {32{o_wb.data[31]}})
    else $error("upper word not sign copy");
  flag_keep_a: assert property (o_ctl_we |-> ctl_kept == $past(ctl_keep))
    else $error("control flags lost");
  match_excl_a: assert property (!(o_wb.valid && o_no_match))
    else $error("result and no match together");
endmodule : dalu_checker
bind dalu_core dalu_checker u_dalu_checker (.i_clk, .i_rst_n, .i_issue, .i_instr, .i_first_source,
  .i_second_source, .i_dsp_control, .o_wb, .o_ctl_we, .o_dsp_control, .o_no_match);

// File: sim/dalu_regfile.sv
`timescale 1ns/1ps
module dalu_regfile (
  input  wire logic               i_clk,
  input  wire dalu_pkg::dalu_wb_t i_wb,
  input  wire dalu_pkg::dalu_wb_t i_ld,
  input  wire logic [4:0]         i_ra,
  input  wire logic [4:0]         i_rb,
  output      logic [63:0]        o_a,
  output      logic [63:0]        o_b
);
  logic [63:0] regs [32];
  // write-back lands one edge after the result is posted
  always_ff @(posedge i_clk) begin
    if (i_ld.valid) regs[i_ld.index] <= i_ld.data;
    else if (i_wb.valid) regs[i_wb.index] <= i_wb.data;
  end
  assign o_a = regs[i_ra];
  assign o_b = regs[i_rb];
endmodule : dalu_regfile

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                  i_clk = 0, i_rst_n = 0, i_issue = 0, o_ctl_we, o_no_match;
  dalu_pkg::dalu_instr_t i_instr = '0;
  logic [31:0]           i_dsp_control = '0, o_dsp_control;
  dalu_pkg::dalu_wb_t    ld = '0, o_wb;
  logic [63:0]           a, b, mdl [32];
  logic [5:0]            fn_t [5] = '{6'h10, 6'h18, 6'h18, 6'h31, 6'h10};
  logic [4:0]            sf_t [5] = '{5'h11, 5'h00, 5'h02, 5'h00, 5'h10};
  int                    n_fail = 0, compares = 0;
  initial forever #4 i_clk = ~i_clk;
  dalu_core u_dalu_core (.i_clk, .i_rst_n, .i_issue, .i_instr, .i_first_source(a),
    .i_second_source(b), .i_dsp_control, .o_wb, .o_ctl_we, .o_dsp_control, .o_no_match);
  dalu_regfile u_dalu_regfile (.i_clk, .i_wb(o_wb), .i_ld(ld),
    .i_ra(i_instr.first_source_index), .i_rb(i_instr.second_source_index), .o_a(a), .o_b(b));
  task automatic chk(string s, logic [68:0] e, logic [68:0] g);
    compares++;
    if (e !== g) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic op(logic [5:0] mj, logic [5:0] fn, logic [4:0] sf, logic [4:0] dd);
    logic [32:0] t;
    logic [31:0] x, y, r, c;
    logic [4:0]  d;
    logic        k, ad, ok;
    i_instr = {mj, 5'($urandom), 5'($urandom), dd, sf, fn};
    i_dsp_control = $urandom;
    i_issue = 1;
    x = mdl[i_instr.first_source_index][31:0];
    y = mdl[i_instr.second_source_index][31:0];
    c = i_dsp_control;
    d = dd;
    ok = mj == 6'h1f;
    ad = ok && fn == 6'h10 && sf == 5'h11;
    k = 1;
    if (ad) begin
      t = {x[31], x} + {y[31], y} + c[13];
      r = t[31:0];
      c[20] = c[20] | (t[32] ^ t[31]);
    end else if (ok && fn == 6'h18 && sf inside {5'h00, 5'h02}) begin
      for (int i = 0; i < 32; i += 8) begin
        t = x[i+:8] + y[i+:8] + sf[1];
        r[i+:8] = t[8:1];
      end
    end else if (ok && fn == 6'h31 && sf == 5'h00) begin
      r = (y << d) | (x & ((32'h1 << d) - 32'h1));
      d = i_instr.second_source_index;
    end else k = 0;
    @(posedge i_clk);
    #1 i_issue = 0;
    chk("valid", 69'(k), 69'(o_wb.valid));
    if (k) chk("wb", {d, {32{r[31]}}, r}, {o_wb.index, o_wb.data});
    chk("ctl_we", 69'(ad), 69'(o_ctl_we));
    if (ad) chk("ctl", 69'(c), 69'(o_dsp_control));
    chk("no_match", 69'(!k), 69'(o_no_match));
    if (k) mdl[d] = {{32{r[31]}}, r};
    @(posedge i_clk);
    #1;
  endtask : op
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // watchdog: about ten times the expected run length
  initial begin
    #40000;
    n_fail++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hfd3c));
    repeat (12) @(posedge i_clk);
    #1 i_rst_n = 1;
    chk("reset_wb", 69'(0), {o_wb.index, o_wb.data});
    chk("reset_flags", 69'(0), 69'({o_wb.valid, o_ctl_we, o_no_match, o_dsp_control}));
    for (int j = 0; j < 32; j++) begin
      ld = {1'b1, 5'(j), 32'($urandom), 32'($urandom)};
      mdl[j] = ld.data;
      @(posedge i_clk);
      #1;
    end
    ld = '0;
    op(6'h1f, 6'h31, 5'h00, 5'h00);
    op(6'h1f, 6'h31, 5'h00, 5'h1f);
    // every seventh issue carries a foreign major opcode and must not match
    for (int n = 0; n < 200; n++)
      op((n % 7 == 3) ? 6'h1e : 6'h1f, fn_t[n % 5], sf_t[n % 5], 5'($urandom));
    complete_run();
  end
endmodule : testbench
